//--- core/ecl_params.svh
`ifndef ECL_PARAMS_SVH
`define ECL_PARAMS_SVH

// register offsets
`define ECL_OFF_CMD    8'h00
`define ECL_OFF_MODE   8'h04
`define ECL_OFF_FEAT   8'h08
`define ECL_OFF_CAP    8'h0c
`define ECL_OFF_RCXL   8'h10
`define ECL_OFF_RCXH   8'h14
`define ECL_OFF_RDXL   8'h18
`define ECL_OFF_RDXH   8'h1c
`define ECL_OFF_DSB    8'h20
`define ECL_OFF_FSGS   8'h24
`define ECL_OFF_FSSAV  8'h28
`define ECL_OFF_TCP    8'h2c
`define ECL_OFF_STAT   8'h30
`define ECL_OFF_RAXL   8'h34
`define ECL_OFF_RAXH   8'h38
`define ECL_OFF_ERR    8'h3c
`define ECL_LKH_SEL    3'h2
// field positions
`define ECL_CMD_GO     0
`define ECL_CMD_OPSZ   1
`define ECL_CMD_CLS    2
`define ECL_M_PROT     0
`define ECL_M_SMM      1
`define ECL_M_V86      2
`define ECL_M_PG       3
`define ECL_M_WIDE     4
`define ECL_M_DSUSE    5
`define ECL_M_DSUP     6
`define ECL_M_BASE0    7
`define ECL_M_SUBSET   8
`define ECL_M_CSWIDE   9
`define ECL_M_ATTRW    10
`define ECL_FC_LOCK    0
`define ECL_FC_LEWR    17
`define ECL_FC_EN      18
`define ECL_F_ZF       0
`define ECL_F_CF       1
`define ECL_F_SF       5
`define ECL_PFEC_BIT   15
// leaf codes and checks
`define ECL_LEAF_CTX   8'h02
`define ECL_LEAF_ENTER 8'h02
`define ECL_LEAF_RES   8'h03
`define ECL_LEAF_EXIT  8'h04
`define ECL_CPL_USER   2'h3
`endif

//--- core/ecl_pkg.sv
package ecl_pkg;
`include "ecl_params.svh"

   typedef enum logic [1:0] {
      ECL_IDLE   = 2'b00,
      ECL_CHECK  = 2'b01,
      ECL_LOOKUP = 2'b10,
      ECL_READ   = 2'b11
   } ecl_state_type;

   typedef enum logic [1:0] {
      ECL_F_NONE = 2'b00,
      ECL_F_GP   = 2'b01,
      ECL_F_PF   = 2'b10,
      ECL_F_UD   = 2'b11
   } ecl_fault_type;

   typedef struct packed {
      ecl_state_type       st;
      logic                pend;
      logic [31:0]         prdata;
      logic [7:0]          leaf;
      logic                cls;
      logic                opsz;
      logic [13:0]         mode;
      logic [31:0]         fc;
      logic [1:0]          cap;
      logic [63:0]         rcx;
      logic [63:0]         rdx;
      logic [31:0]         dsb;
      logic [31:0]         fsgs;
      logic [31:0]         fsgs_sav;
      logic [31:0]         fsgs_tcp;
      logic [63:0]         rax;
      logic [5:0]          flg;
      ecl_fault_type       fault;
      logic                done;
      logic                done_p;
      logic [63:0]         stage;
      logic                pc_val;
      logic [7:0]          pc_type;
      logic                pc_busy;
      logic [7:0][31:0]    lkh;
      logic                mem_req;
      logic                pcm_req;
      logic [63:0]         mem_addr;
      logic [63:0]         ctx_addr;
      logic                ctx_wr;
   } ecl_regs_type;
endpackage

//--- core/ecl_leaf_unit.sv
`timescale 1ns/10ps
`include "ecl_params.svh"
module ecl_leaf_unit
   import ecl_pkg::*;
#(
   parameter logic [63:0] CONFLICT_CODE = 64'h0000_0000_0000_0001,
   parameter logic [7:0]  CTL_PAGE_TYPE = 8'h00
)(
   // clock and reset
   input  wire logic        MCLK_I,
   input  wire logic        RESET_N_I,
   // apb slave
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [31:0] PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   // page cache map lookup
   output logic             PCM_REQ_O,
   output logic      [63:0] PCM_ADDR_O,
   input  wire logic        PCM_ACK_I,
   input  wire logic        PCM_RESIDENT_I,
   input  wire logic        PCM_VALID_I,
   input  wire logic [7:0]  PCM_TYPE_I,
   input  wire logic        PCM_BUSY_I,
   // context value read
   output logic             MEM_REQ_O,
   output logic      [63:0] MEM_ADDR_O,
   input  wire logic        MEM_ACK_I,
   input  wire logic [63:0] MEM_RDATA_I,
   // context field write
   output logic             CTX_WR_O,
   output logic      [63:0] CTX_ADDR_O,
   output logic      [63:0] CTX_WDATA_O,
   // fs/gs segment state
   input  wire logic        ASYNC_EXIT_I,
   output logic      [31:0] FSGS_O,
   // leaf status
   output logic             BUSY_O,
   output logic             DONE_O
);

   ecl_regs_type  r_reg;
   ecl_regs_type  r_next;
   logic [31:0]   rd_data;
   logic          bad;
   logic          lkh_hit;
   logic [2:0]    lkh_idx;
   logic          lkh_on;
   logic          lkh_wr_ok;
   logic          commit;
   logic          wide;
   logic [63:0]   lin_rcx;
   logic [63:0]   lin_rdx;
   logic          fin;
   ecl_fault_type fin_f;

   // linear address from a data segment offset; the override and
   // address-size prefixes never reach this path
   function automatic logic [63:0] lin_of(
      input logic [63:0] off,
      input logic [31:0] base,
      input logic        w
   );
      logic [63:0] s;
      s = (w ? off : {32'h0, off[31:0]}) + {32'h0, base};
      lin_of = w ? s : {32'h0, s[31:0]};
   endfunction

   // address mode and operand addresses
   assign wide    = r_reg.mode[`ECL_M_WIDE];
   assign lin_rcx = lin_of(r_reg.rcx, r_reg.dsb, wide);
   assign lin_rdx = lin_of(r_reg.rdx, r_reg.dsb, wide);

   // key hash presence and write gating
   assign lkh_on    = r_reg.cap[0] & r_reg.cap[1];
   assign lkh_wr_ok = r_reg.fc[`ECL_FC_LEWR] &
                      r_reg.fc[`ECL_FC_LOCK];
   assign lkh_idx   = PADDR_I[4:2];
   assign lkh_hit   = (PADDR_I[7:5] == `ECL_LKH_SEL) &
                      (PADDR_I[1:0] == 2'h0);

   // read mux and address decode
   always_comb begin
      rd_data = 32'h0;
      bad     = 1'b0;
      if (lkh_hit) begin
         if (lkh_on) begin
            rd_data = r_reg.lkh[lkh_idx];
         end else begin
            bad = 1'b1; // absent registers answer with an error
         end
      end else begin
         case (PADDR_I[7:0])
            `ECL_OFF_CMD: begin
               rd_data = {16'h0, r_reg.leaf, 5'h0, r_reg.cls,
                          r_reg.opsz, 1'b0};
            end
            `ECL_OFF_MODE:  rd_data = {18'h0, r_reg.mode};
            `ECL_OFF_FEAT:  rd_data = r_reg.fc;
            `ECL_OFF_CAP:   rd_data = {30'h0, r_reg.cap};
            `ECL_OFF_RCXL:  rd_data = r_reg.rcx[31:0];
            `ECL_OFF_RCXH:  rd_data = r_reg.rcx[63:32];
            `ECL_OFF_RDXL:  rd_data = r_reg.rdx[31:0];
            `ECL_OFF_RDXH:  rd_data = r_reg.rdx[63:32];
            `ECL_OFF_DSB:   rd_data = r_reg.dsb;
            `ECL_OFF_FSGS:  rd_data = r_reg.fsgs;
            `ECL_OFF_FSSAV: rd_data = r_reg.fsgs_sav;
            `ECL_OFF_TCP:   rd_data = r_reg.fsgs_tcp;
            `ECL_OFF_STAT: begin
               rd_data = {22'h0, r_reg.flg, r_reg.fault, r_reg.done,
                          (r_reg.st != ECL_IDLE)};
            end
            `ECL_OFF_RAXL:  rd_data = r_reg.rax[31:0];
            `ECL_OFF_RAXH:  rd_data = r_reg.rax[63:32];
            `ECL_OFF_ERR: begin
               // gp faults carry error code zero
               if (r_reg.fault == ECL_F_PF) begin
                  rd_data = 32'h1 << `ECL_PFEC_BIT;
               end
            end
            default: bad = 1'b1;
         endcase
      end
   end

   // write takes effect at the edge where pready is seen high
   assign commit = PSEL_I & PENABLE_I & r_reg.pend & PWRITE_I & ~bad;

   // next state of the whole unit
   always_comb begin
      r_next = r_reg;
      fin    = 1'b0;
      fin_f  = ECL_F_NONE;
      r_next.ctx_wr = 1'b0;
      r_next.done_p = 1'b0;

      // one wait state so read data comes from a flip-flop
      if (PSEL_I & PENABLE_I & ~r_reg.pend) begin
         r_next.pend   = 1'b1;
         r_next.prdata = rd_data;
      end else begin
         r_next.pend = 1'b0;
      end

      // register writes; operands are software's to keep still
      if (commit & lkh_hit) begin
         if (lkh_wr_ok) begin
            r_next.lkh[lkh_idx] = PWDATA_I;
         end
      end else if (commit) begin
         case (PADDR_I[7:0])
            `ECL_OFF_CMD: begin
               if (r_reg.st == ECL_IDLE && PWDATA_I[`ECL_CMD_GO]) begin
                  r_next.leaf  = PWDATA_I[15:8];
                  r_next.cls   = PWDATA_I[`ECL_CMD_CLS];
                  r_next.opsz  = PWDATA_I[`ECL_CMD_OPSZ];
                  r_next.done  = 1'b0;
                  r_next.fault = ECL_F_NONE;
                  r_next.st    = ECL_CHECK;
               end
            end
            `ECL_OFF_MODE: r_next.mode = PWDATA_I[13:0];
            `ECL_OFF_FEAT: begin
               // lock bit freezes the whole register until reset
               if (!r_reg.fc[`ECL_FC_LOCK]) begin
                  r_next.fc = PWDATA_I;
               end
            end
            `ECL_OFF_CAP:  r_next.cap = PWDATA_I[1:0];
            `ECL_OFF_RCXL: r_next.rcx[31:0] = PWDATA_I;
            `ECL_OFF_RCXH: r_next.rcx[63:32] = PWDATA_I;
            `ECL_OFF_RDXL: r_next.rdx[31:0] = PWDATA_I;
            `ECL_OFF_RDXH: r_next.rdx[63:32] = PWDATA_I;
            `ECL_OFF_DSB:  r_next.dsb = PWDATA_I;
            `ECL_OFF_FSGS: r_next.fsgs = PWDATA_I;
            `ECL_OFF_TCP:  r_next.fsgs_tcp = PWDATA_I;
            default: ;
         endcase
      end

      // leaf sequencer
      unique case (r_reg.st)
         ECL_IDLE: ;
         ECL_CHECK: begin
            if (!r_reg.mode[`ECL_M_PROT] || r_reg.mode[`ECL_M_SMM] ||
                r_reg.mode[`ECL_M_V86]) begin
               fin   = 1'b1;
               fin_f = ECL_F_UD;
            end else if (!r_reg.mode[`ECL_M_PG]) begin
               fin   = 1'b1;
               fin_f = ECL_F_UD;
            end else if (!(r_reg.fc[`ECL_FC_EN] &&
                           r_reg.fc[`ECL_FC_LOCK])) begin
               fin   = 1'b1;
               fin_f = ECL_F_UD;
            end else if (r_reg.opsz) begin
               fin   = 1'b1;
               fin_f = ECL_F_UD;
            end else if (!r_reg.mode[`ECL_M_DSUSE] ||
                         !r_reg.mode[`ECL_M_DSUP]) begin
               fin   = 1'b1;
               fin_f = ECL_F_GP;
            end else if (r_reg.cls) begin
               if (r_reg.leaf != `ECL_LEAF_CTX) begin
                  fin   = 1'b1; // unknown leaf
                  fin_f = ECL_F_GP;
               end else if (r_reg.rcx[11:0] != 12'h000) begin
                  fin   = 1'b1;
                  fin_f = ECL_F_GP;
               end else begin
                  r_next.ctx_addr = lin_rcx;
                  r_next.pcm_req  = 1'b1;
                  r_next.st       = ECL_LOOKUP;
               end
            end else if (r_reg.leaf == `ECL_LEAF_ENTER ||
                         r_reg.leaf == `ECL_LEAF_RES) begin
               if (!r_reg.mode[`ECL_M_BASE0]) begin
                  fin   = 1'b1;
                  fin_f = ECL_F_GP;
               end else if (!r_reg.mode[`ECL_M_SUBSET]) begin
                  fin   = 1'b1;
                  fin_f = ECL_F_GP;
               end else if (r_reg.mode[13:12] != `ECL_CPL_USER ||
                            r_reg.mode[`ECL_M_CSWIDE] !=
                            r_reg.mode[`ECL_M_ATTRW]) begin
                  fin   = 1'b1;
                  fin_f = ECL_F_GP;
               end else begin
                  // full state incl. hidden part is one word here
                  r_next.fsgs_sav = r_reg.fsgs;
                  r_next.fsgs     = r_reg.fsgs_tcp;
                  fin             = 1'b1;
               end
            end else if (r_reg.leaf == `ECL_LEAF_EXIT) begin
               r_next.fsgs = r_reg.fsgs_sav;
               fin         = 1'b1;
            end else begin
               fin   = 1'b1; // unknown leaf
               fin_f = ECL_F_GP;
            end
         end
         ECL_LOOKUP: begin
            if (PCM_ACK_I) begin
               r_next.pcm_req = 1'b0;
               r_next.pc_val  = PCM_VALID_I;
               r_next.pc_type = PCM_TYPE_I;
               r_next.pc_busy = PCM_BUSY_I;
               if (!PCM_RESIDENT_I) begin
                  fin   = 1'b1;
                  fin_f = ECL_F_PF;
               end else if (r_reg.rdx[2:0] != 3'h0) begin
                  fin   = 1'b1;
                  fin_f = ECL_F_GP;
               end else begin
                  r_next.mem_addr = lin_rdx;
                  r_next.mem_req  = 1'b1;
                  r_next.st       = ECL_READ;
               end
            end
         end
         ECL_READ: begin
            if (MEM_ACK_I) begin
               r_next.mem_req = 1'b0;
               r_next.stage   = MEM_RDATA_I;
               // busy was caught at lookup, acted on after staging
               if (r_reg.pc_busy) begin
                  r_next.flg[`ECL_F_ZF] = 1'b1;
                  r_next.rax            = CONFLICT_CODE;
                  fin                   = 1'b1;
               end else if (!r_reg.pc_val) begin
                  fin   = 1'b1;
                  fin_f = ECL_F_PF;
               end else if (r_reg.pc_type != CTL_PAGE_TYPE) begin
                  fin   = 1'b1;
                  fin_f = ECL_F_PF;
               end else begin
                  r_next.ctx_wr         = 1'b1;
                  r_next.rax            = 64'h0;
                  r_next.flg[`ECL_F_ZF] = 1'b0;
                  fin                   = 1'b1;
               end
            end
         end
      endcase

      // completion; a fault leaves result, flags and field alone
      if (fin) begin
         r_next.st     = ECL_IDLE;
         r_next.done   = 1'b1;
         r_next.done_p = 1'b1;
         r_next.fault  = fin_f;
         if (fin_f == ECL_F_NONE && r_reg.cls) begin
            r_next.flg[`ECL_F_SF:`ECL_F_CF] = 5'h00;
         end
      end

      // asynchronous exit restores the saved segment state
      if (ASYNC_EXIT_I) begin
         r_next.fsgs = r_reg.fsgs_sav;
      end
   end

   // all state in one register
   always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // outputs
   assign PRDATA_O    = r_reg.prdata;
   assign PREADY_O    = r_reg.pend;
   assign PSLVERR_O   = r_reg.pend & bad;
   assign PCM_REQ_O   = r_reg.pcm_req;
   assign PCM_ADDR_O  = r_reg.ctx_addr;
   assign MEM_REQ_O   = r_reg.mem_req;
   assign MEM_ADDR_O  = r_reg.mem_addr;
   assign CTX_WR_O    = r_reg.ctx_wr;
   assign CTX_ADDR_O  = r_reg.ctx_addr;
   assign CTX_WDATA_O = r_reg.stage;
   assign FSGS_O      = r_reg.fsgs;
   assign BUSY_O      = (r_reg.st != ECL_IDLE);
   assign DONE_O      = r_reg.done_p;

endmodule

//--- bench/ecl_leaf_sva.sv
`timescale 1ns/10ps
module ecl_leaf_sva
   import ecl_pkg::*;
#(
   parameter logic [7:0] CTL_PAGE_TYPE = 8'h00
)(
   // clock and reset
   input wire logic        MCLK_I,
   input wire logic        RESET_N_I,
   // apb answer
   input wire logic        PREADY_O,
   input wire logic        PSLVERR_O,
   // lookup and staging read
   input wire logic        PCM_REQ_O,
   input wire logic        PCM_ACK_I,
   input wire logic        PCM_RESIDENT_I,
   input wire logic        PCM_VALID_I,
   input wire logic [7:0]  PCM_TYPE_I,
   input wire logic        PCM_BUSY_I,
   input wire logic        MEM_REQ_O,
   input wire logic        MEM_ACK_I,
   input wire logic [63:0] MEM_RDATA_I,
   // field write and status
   input wire logic        CTX_WR_O,
   input wire logic [63:0] CTX_WDATA_O,
   input wire logic        BUSY_O,
   input wire logic        DONE_O
);
   logic ok_q;

   // page verdict kept from lookup, since busy is acted on after the read
   always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         ok_q <= 1'b0;
      end else if (PCM_REQ_O && PCM_ACK_I) begin
         ok_q <= !PCM_BUSY_I && PCM_VALID_I && PCM_TYPE_I == CTL_PAGE_TYPE;
      end
   end

   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RESET_N_I);

   // bus answers and request holding
   a_slverr_ready: assert property (PSLVERR_O |-> PREADY_O)
      else $error("error response without ready");
   a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
      else $error("ready longer than one cycle");
   a_lookup_hold: assert property (PCM_REQ_O && !PCM_ACK_I |=> PCM_REQ_O)
      else $error("lookup dropped before answer");
   a_read_hold: assert property (MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O)
      else $error("read dropped before answer");
   // check order of the context-set leaf
   a_lookup_first: assert property (!(PCM_REQ_O && MEM_REQ_O))
      else $error("lookup and read overlap");
   a_read_after_res: assert property ($rose(MEM_REQ_O) |->
      $past(PCM_ACK_I) && $past(PCM_RESIDENT_I))
      else $error("read without resident lookup");
   a_nonres_stop: assert property (
      PCM_REQ_O && PCM_ACK_I && !PCM_RESIDENT_I |=> DONE_O && !MEM_REQ_O)
      else $error("absent page did not end leaf");
   a_store_staged: assert property (CTX_WR_O |->
      $past(MEM_ACK_I) && CTX_WDATA_O == $past(MEM_RDATA_I))
      else $error("stored value is not the staged one");
   a_store_gate: assert property (
      MEM_REQ_O && MEM_ACK_I |=> DONE_O && CTX_WR_O == ok_q)
      else $error("field write against page verdict");
   a_done_ends: assert property (DONE_O |-> !BUSY_O && $past(BUSY_O))
      else $error("completion without busy leaf");

   c_store: cover property (CTX_WR_O);
   c_conflict: cover property (MEM_ACK_I ##1 DONE_O && !CTX_WR_O);
   c_slverr: cover property (PSLVERR_O);
endmodule

bind ecl_leaf_unit ecl_leaf_sva #(.CTL_PAGE_TYPE(CTL_PAGE_TYPE)) i_sva (.*);

//--- bench/tb.sv
`timescale 1ns/10ps
module tb;
   import ecl_pkg::*;
   localparam logic [63:0] CONF = 64'h0000_0000_0000_00c3;
   localparam logic [7:0]  PTYP = 8'h05;
   localparam logic [31:0] OK = 32'h002, GP = 32'h006, PF = 32'h00a;
   localparam logic [31:0] UD = 32'h00e, ZF = 32'h010;
   localparam logic [31:0] MOK = 32'h79, MENT = 32'h37f9;
   localparam logic [15:0] CTXC = 16'h0205, ENT = 16'h0201;
   localparam logic [15:0] RES = 16'h0301, EXT = 16'h0401;
   logic        mclk = 1'b0, reset_n = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = '0, pwdata = '0, rdata, prdata, fsgs;
   logic        serr, pready, pslverr, pcm_req, mem_req, ctx_wr, done;
   logic        busy;
   logic        pcm_ack = 1'b0, mem_ack = 1'b0, async_x = 1'b0;
   logic        p_res = 1'b0, p_val = 1'b0, p_busy = 1'b0;
   logic [7:0]  p_typ = 8'h00;
   logic [63:0] ctx_v = '0, wdat, waddr, pcm_a, mem_a, ctx_a, ctx_d;
   logic [31:0] bad[4] = '{32'h78, 32'h7b, 32'h7d, 32'h71};
   logic [31:0] ebad[4] = '{32'h3779, 32'h36f9, 32'h35f9, 32'h27f9};
   int          n_mismatch = 0, cmp_count = 0, n_wr = 0, cnt = 0;
   int          lat = 0, cyc = 0;

   ecl_leaf_unit #(.CONFLICT_CODE(CONF), .CTL_PAGE_TYPE(PTYP)) i_dut (
      .MCLK_I(mclk), .RESET_N_I(reset_n), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .PCM_REQ_O(pcm_req), .PCM_ADDR_O(pcm_a),
      .PCM_ACK_I(pcm_ack), .PCM_RESIDENT_I(pcm_ack ? p_res : !p_res),
      .PCM_VALID_I(pcm_ack ? p_val : !p_val),
      .PCM_TYPE_I(pcm_ack ? p_typ : ~p_typ),
      .PCM_BUSY_I(pcm_ack ? p_busy : !p_busy), .MEM_REQ_O(mem_req),
      .MEM_ADDR_O(mem_a), .MEM_ACK_I(mem_ack),
      .MEM_RDATA_I(mem_ack ? ctx_v : ~ctx_v), .CTX_WR_O(ctx_wr),
      .CTX_ADDR_O(ctx_a), .CTX_WDATA_O(ctx_d), .ASYNC_EXIT_I(async_x),
      .FSGS_O(fsgs), .BUSY_O(busy), .DONE_O(done));

   initial begin
      forever #25 mclk = ~mclk;
   end

   // far side answers lat+1 cycles after a request; data lines flip outside answers
   always @(posedge mclk) begin
      if ((pcm_req && !pcm_ack) || (mem_req && !mem_ack)) cnt <= cnt + 1;
      else cnt <= 0;
      pcm_ack <= pcm_req && !pcm_ack && cnt >= lat;
      mem_ack <= mem_req && !mem_ack && cnt >= lat;
   end

   // field writes seen, and a hang guard well above the sequence length
   always @(posedge mclk) begin
      if (ctx_wr === 1'b1) begin
         n_wr <= n_wr + 1;
         wdat <= ctx_d;
         waddr <= ctx_a;
      end
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_mismatch++;
         complete_run();
      end
   end

   task automatic chk(input string nm, input logic [63:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // request held until the edge that samples ready
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rdata = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a,
                         input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, {32'h0, rdata}, {32'h0, exp});
   endtask

   task automatic setq(input logic [7:0] a, input logic [63:0] v);
      wr(a, v[31:0]);
      wr(a + 8'h04, v[63:32]);
   endtask

   // one leaf: mode, command, wait for completion, status and write count
   task automatic leaf(input logic [15:0] cmd, input logic [31:0] mode,
                       input logic [31:0] st, input int nw);
      int n0;
      n0 = n_wr;
      wr(8'h04, mode);
      wr(8'h00, {16'h0, cmd});
      do @(posedge mclk); while (done !== 1'b1);
      apb(1'b0, 8'h30, 32'h0);
      chk("status", {32'h0, rdata & 32'h3ff}, {32'h0, st});
      chk("field writes", 64'(n_wr - n0), 64'(nw));
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge mclk);
      reset_n <= 1'b1;
      wr(8'h0c, 32'h3);
      wr(8'h08, 32'h0006_0000);
      wr(8'h20, 32'h1000);
      wr(8'h40, 32'ha5a5_0001);
      rd_chk("hash unlocked", 8'h40, 32'h0);
      leaf(CTXC, MOK, UD, 0);
      wr(8'h08, 32'h0006_0001);
      wr(8'h08, 32'h0);
      rd_chk("feature lock", 8'h08, 32'h0006_0001);
      wr(8'h40, 32'ha5a5_0001);
      rd_chk("hash locked", 8'h40, 32'ha5a5_0001);
      for (int i = 1; i < 3; i++) begin
         wr(8'h0c, 32'(i));
         apb(1'b0, 8'h40, 32'h0);
         chk("hash absent", {63'h0, serr}, 64'h1);
      end
      wr(8'h0c, 32'h3);
      apb(1'b0, 8'hfc, 32'h0);
      chk("unmapped", {31'h0, serr, rdata}, {32'h1, 32'h0});
      $display("test availability done");
      foreach (bad[i]) leaf(CTXC, bad[i], UD, 0);
      leaf(CTXC | 16'h0002, MOK, UD, 0);
      leaf(CTXC, 32'h59, GP, 0);
      leaf(CTXC, 32'h39, GP, 0);
      leaf(16'h0305, MOK, GP, 0);
      setq(8'h10, 64'h1001);
      leaf(CTXC, MOK, GP, 0);
      rd_chk("gp code", 8'h3c, 32'h0);
      setq(8'h10, 64'h5000);
      setq(8'h18, 64'h2004);
      leaf(CTXC, MOK, PF, 0);
      rd_chk("pf code", 8'h3c, 32'h8000);
      p_res <= 1'b1;
      leaf(CTXC, MOK, GP, 0);
      $display("test qualification done");
      setq(8'h18, 64'h2008);
      p_busy <= 1'b1;
      p_val <= 1'b1;
      p_typ <= PTYP;
      ctx_v <= 64'h1122_3344_5566_7788;
      leaf(CTXC, MOK, ZF | OK, 0);
      rd_chk("conflict code", 8'h34, CONF[31:0]);
      p_busy <= 1'b0;
      p_val <= 1'b0;
      leaf(CTXC, MOK, ZF | PF, 0);
      rd_chk("result kept", 8'h34, CONF[31:0]);
      p_val <= 1'b1;
      p_typ <= ~PTYP;
      leaf(CTXC, MOK, ZF | PF, 0);
      p_typ <= PTYP;
      lat = 3;
      leaf(CTXC, MOK, OK, 1);
      chk("context value", wdat, ctx_v);
      rd_chk("result", 8'h34, 32'h0);
      setq(8'h10, 64'h1_0000_5000);
      leaf(CTXC, 32'h69, OK, 1);
      chk("linear address", waddr, 64'h6000);
      chk("lookup address", pcm_a, 64'h6000);
      chk("read address", mem_a, 64'h3008);
      chk("busy idle", {63'h0, busy}, 64'h0);
      $display("test context set done");
      wr(8'h24, 32'haaaa_0001);
      wr(8'h2c, 32'hbbbb_0002);
      foreach (ebad[i]) leaf(ENT, ebad[i], GP, 0);
      rd_chk("fsgs kept", 8'h24, 32'haaaa_0001);
      leaf(ENT, MENT, OK, 0);
      rd_chk("fsgs loaded", 8'h24, 32'hbbbb_0002);
      rd_chk("fsgs saved", 8'h28, 32'haaaa_0001);
      leaf(EXT, MENT, OK, 0);
      rd_chk("fsgs exit", 8'h24, 32'haaaa_0001);
      leaf(RES, MENT, OK, 0);
      @(posedge mclk);
      async_x <= 1'b1;
      @(posedge mclk);
      async_x <= 1'b0;
      rd_chk("fsgs async", 8'h24, 32'haaaa_0001);
      chk("fsgs pin", {32'h0, fsgs}, 64'haaaa_0001);
      $display("test segment swap done");
      complete_run();
   end
endmodule
